// File: src/dual_bank_io_port_regs.sv
// Register block and pad control for two general-purpose I/O banks.
// Assumes a master on the plain register port that never needs a wait,
// and board pins that are asynchronous to clk.
//
// Functional notes
// RULE1 - Bank A direction bits 6..0 per line, 1 output, reset 0.
// RULE2 - Bank A output lines follow value register; bits reset to 1.
// RULE3 - Bank A pin level register reads every pin, whatever its use.
// RULE4 - Bank A driver bit 0 open drain, 1 push-pull, reset 0.
// RULE5 - Bank B direction bits 7..4 and 2..0, bit 3 reserved.
// RULE6 - Bank B output lines follow value register; bits reset to 1.
// RULE7 - Bank B pin level register reads live pins, bit 3 reserved.
// RULE8 - Bank B driver bit 0 open drain, 1 push-pull, reset 0.
// RULE9 - Open drain pulls low for 0, releases for 1; inputs undriven.
// RULE10 - Pin level writes ignored; pins synchronised before readback.
`timescale 1ns/10ps
`default_nettype none
module dual_bank_io_port_regs
   import gpio_pkg::*;
(
   input wire logic clk,
   input wire logic reset_n,
   input wire logic [7:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [7:0] reg_rdata,
   input wire logic [6:0] bank_a_pin_in,
   output logic [6:0] bank_a_pin_out,
   output logic [6:0] bank_a_pin_oe,
   input wire logic [7:0] bank_b_pin_in,
   output logic [7:0] bank_b_pin_out,
   output logic [7:0] bank_b_pin_oe
);

   // Address decode shared by the write and the read path.
   function automatic reg_sel_type reg_select(input logic [7:0] addr);
      reg_sel_type sel;
      sel = SEL_NONE;
      if (addr == BANK_A_DIRECTION_OFFSET) begin
         sel = SEL_A_DIRECTION;
      end else if (addr == BANK_A_OUTPUT_VALUE_OFFSET) begin
         sel = SEL_A_OUTPUT_VALUE;
      end else if (addr == BANK_A_PIN_LEVEL_OFFSET) begin
         sel = SEL_A_PIN_LEVEL;
      end else if (addr == BANK_A_DRIVER_TYPE_OFFSET) begin
         sel = SEL_A_DRIVER_TYPE;
      end else if (addr == BANK_B_DIRECTION_OFFSET) begin
         sel = SEL_B_DIRECTION;
      end else if (addr == BANK_B_OUTPUT_VALUE_OFFSET) begin
         sel = SEL_B_OUTPUT_VALUE;
      end else if (addr == BANK_B_PIN_LEVEL_OFFSET) begin
         sel = SEL_B_PIN_LEVEL;
      end else if (addr == BANK_B_DRIVER_TYPE_OFFSET) begin
         sel = SEL_B_DRIVER_TYPE;
      end
      return sel;
   endfunction : reg_select

   reg_req_type req;
   reg_sel_type wr_sel;
   reg_sel_type rd_sel;

   assign req.addr = reg_addr;
   assign req.wdata = reg_wdata;
   assign req.wr = reg_wr;
   assign req.rd = reg_rd;

   assign wr_sel = reg_select(req.addr);
   assign rd_sel = reg_select(req.addr);

   // Write strobes for each writable register.
   logic wr_a_direction;
   logic wr_a_output_value;
   logic wr_a_driver_type;
   logic wr_b_direction;
   logic wr_b_output_value;
   logic wr_b_driver_type;

   // RULE1 direction write decode.
   assign wr_a_direction = req.wr && (wr_sel == SEL_A_DIRECTION);
   // RULE2 value write decode.
   assign wr_a_output_value = req.wr && (wr_sel == SEL_A_OUTPUT_VALUE);
   // RULE4 driver write decode.
   assign wr_a_driver_type = req.wr && (wr_sel == SEL_A_DRIVER_TYPE);
   // RULE5 direction write decode.
   assign wr_b_direction = req.wr && (wr_sel == SEL_B_DIRECTION);
   // RULE6 value write decode.
   assign wr_b_output_value = req.wr && (wr_sel == SEL_B_OUTPUT_VALUE);
   // RULE8 driver write decode.
   assign wr_b_driver_type = req.wr && (wr_sel == SEL_B_DRIVER_TYPE);

   // Control registers, one flop group each. Reserved bits are writable
   // storage that reads back but never reaches a pad.
   logic [7:0] bank_a_direction_q;
   logic [7:0] bank_a_direction_d;
   logic [7:0] bank_a_output_value_q;
   logic [7:0] bank_a_output_value_d;
   logic [7:0] bank_a_driver_type_q;
   logic [7:0] bank_a_driver_type_d;
   logic [7:0] bank_b_direction_q;
   logic [7:0] bank_b_direction_d;
   logic [7:0] bank_b_output_value_q;
   logic [7:0] bank_b_output_value_d;
   logic [7:0] bank_b_driver_type_q;
   logic [7:0] bank_b_driver_type_d;
   bank_ctrl_type bank_a_ctrl;
   bank_ctrl_type bank_b_ctrl;

   // RULE1 bank A direction next value.
   assign bank_a_direction_d = wr_a_direction ? req.wdata
                               : bank_a_direction_q;
   // RULE2 bank A output value next value.
   assign bank_a_output_value_d = wr_a_output_value ? req.wdata
                                  : bank_a_output_value_q;
   // RULE4 bank A driver type next value.
   assign bank_a_driver_type_d = wr_a_driver_type ? req.wdata
                                 : bank_a_driver_type_q;

   // RULE5 bank B direction next value.
   assign bank_b_direction_d = wr_b_direction ? req.wdata
                               : bank_b_direction_q;
   // RULE6 bank B output value next value.
   assign bank_b_output_value_d = wr_b_output_value ? req.wdata
                                  : bank_b_output_value_q;
   // RULE8 bank B driver type next value.
   assign bank_b_driver_type_d = wr_b_driver_type ? req.wdata
                                 : bank_b_driver_type_q;

   // RULE1 bank A direction storage.
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         bank_a_direction_q <= DIRECTION_RESET;
      end else begin
         bank_a_direction_q <= bank_a_direction_d;
      end
   end

   // RULE2 bank A value storage.
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         bank_a_output_value_q <= OUTPUT_VALUE_RESET;
      end else begin
         bank_a_output_value_q <= bank_a_output_value_d;
      end
   end

   // RULE4 bank A driver storage.
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         bank_a_driver_type_q <= DRIVER_TYPE_RESET;
      end else begin
         bank_a_driver_type_q <= bank_a_driver_type_d;
      end
   end

   // RULE5 bank B direction storage.
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         bank_b_direction_q <= DIRECTION_RESET;
      end else begin
         bank_b_direction_q <= bank_b_direction_d;
      end
   end

   // RULE6 bank B value storage.
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         bank_b_output_value_q <= OUTPUT_VALUE_RESET;
      end else begin
         bank_b_output_value_q <= bank_b_output_value_d;
      end
   end

   // RULE8 bank B driver storage.
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         bank_b_driver_type_q <= DRIVER_TYPE_RESET;
      end else begin
         bank_b_driver_type_q <= bank_b_driver_type_d;
      end
   end

   // Registers bundled per bank for the pad drivers.
   assign bank_a_ctrl.direction = bank_a_direction_q;
   assign bank_a_ctrl.output_value = bank_a_output_value_q;
   assign bank_a_ctrl.driver_type = bank_a_driver_type_q;
   assign bank_b_ctrl.direction = bank_b_direction_q;
   assign bank_b_ctrl.output_value = bank_b_output_value_q;
   assign bank_b_ctrl.driver_type = bank_b_driver_type_q;

   // Pin level readback path.
   logic [7:0] bank_a_pin_raw;
   logic [7:0] bank_a_level_sync;
   logic [7:0] bank_b_level_sync;
   logic [7:0] bank_a_level;
   logic [7:0] bank_b_level;

   // Bank A has no pin on bit 7.
   assign bank_a_pin_raw = {1'b0, bank_a_pin_in};

   // RULE10 bank A pins synchronised.
   pin_sync bank_a_sync (
      .clk(clk),
      .reset_n(reset_n),
      .pin_async(bank_a_pin_raw),
      .pin_level(bank_a_level_sync)
   );

   // RULE10 bank B pins synchronised.
   pin_sync bank_b_sync (
      .clk(clk),
      .reset_n(reset_n),
      .pin_async(bank_b_pin_in),
      .pin_level(bank_b_level_sync)
   );

   // The pad is sampled whatever drives it, so an output line reads
   // back its own driven level and an alternate-use pin its live level.
   // RULE3 bank A live level.
   assign bank_a_level = bank_a_level_sync & BANK_A_LINE_MASK;
   // RULE7 bank B live level.
   assign bank_b_level = bank_b_level_sync & BANK_B_LINE_MASK;

   // Read data mux; unmapped addresses read zero.
   logic [7:0] rd_mux;
   logic [7:0] rdata_q;
   logic [7:0] rdata_d;

   always_comb begin
      rd_mux = READ_IDLE;
      case (rd_sel)
         SEL_A_DIRECTION: begin
            rd_mux = bank_a_direction_q;
         end
         SEL_A_OUTPUT_VALUE: begin
            rd_mux = bank_a_output_value_q;
         end
         // RULE3 bank A level read.
         SEL_A_PIN_LEVEL: begin
            rd_mux = bank_a_level;
         end
         SEL_A_DRIVER_TYPE: begin
            rd_mux = bank_a_driver_type_q;
         end
         SEL_B_DIRECTION: begin
            rd_mux = bank_b_direction_q;
         end
         SEL_B_OUTPUT_VALUE: begin
            rd_mux = bank_b_output_value_q;
         end
         // RULE7 bank B level read.
         SEL_B_PIN_LEVEL: begin
            rd_mux = bank_b_level;
         end
         SEL_B_DRIVER_TYPE: begin
            rd_mux = bank_b_driver_type_q;
         end
         default: begin
            rd_mux = READ_IDLE;
         end
      endcase
   end

   // Read data stands only in the cycle after the read strobe.
   assign rdata_d = req.rd ? rd_mux : READ_IDLE;

   always_ff @(posedge clk) begin
      if (!reset_n) begin
         rdata_q <= READ_IDLE;
      end else begin
         rdata_q <= rdata_d;
      end
   end

   assign reg_rdata = rdata_q;

   // RULE10 level registers ignore writes.
   // No write strobe exists for SEL_A_PIN_LEVEL or SEL_B_PIN_LEVEL, so a
   // write there leaves every register unchanged.

   // Pad drivers.
   pad_out_type bank_a_pads;
   pad_out_type bank_b_pads;

   // RULE2 RULE4 RULE9 bank A pad drive.
   bank_pins #(
      .LINE_MASK(BANK_A_LINE_MASK)
   ) bank_a_drv (
      .clk(clk),
      .reset_n(reset_n),
      .ctrl(bank_a_ctrl),
      .pads(bank_a_pads)
   );

   // RULE6 RULE8 RULE9 bank B pad drive.
   bank_pins #(
      .LINE_MASK(BANK_B_LINE_MASK)
   ) bank_b_drv (
      .clk(clk),
      .reset_n(reset_n),
      .ctrl(bank_b_ctrl),
      .pads(bank_b_pads)
   );

   // Each pad takes its own bit; bank A bit 7 has no pad at all.
   for (genvar i = 0; i < BANK_A_LINES; i++) begin : g_bank_a_pad
      assign bank_a_pin_out[i] = bank_a_pads.drive[i];
      assign bank_a_pin_oe[i] = bank_a_pads.enable[i];
   end

   // Bank B line 3 is reserved; its driver is kept off by the mask.
   for (genvar i = 0; i < DATA_W; i++) begin : g_bank_b_pad
      assign bank_b_pin_out[i] = bank_b_pads.drive[i];
      assign bank_b_pin_oe[i] = bank_b_pads.enable[i];
   end

endmodule : dual_bank_io_port_regs
`default_nettype wire

// File: src/gpio_pkg.sv
// Constants, register map and carrier types for the two-bank I/O port.
// Assumes a single 250 MHz clock and an 8-bit register port.
`default_nettype none
package gpio_pkg;

   // Register port width.
   localparam int unsigned DATA_W = 8;

   // Register offsets, bank A.
   localparam logic [7:0] BANK_A_DIRECTION_OFFSET = 8'he0;
   localparam logic [7:0] BANK_A_OUTPUT_VALUE_OFFSET = 8'he1;
   localparam logic [7:0] BANK_A_PIN_LEVEL_OFFSET = 8'he2;
   localparam logic [7:0] BANK_A_DRIVER_TYPE_OFFSET = 8'he3;

   // Register offsets, bank B.
   localparam logic [7:0] BANK_B_DIRECTION_OFFSET = 8'hd0;
   localparam logic [7:0] BANK_B_OUTPUT_VALUE_OFFSET = 8'hd1;
   localparam logic [7:0] BANK_B_PIN_LEVEL_OFFSET = 8'hd2;
   localparam logic [7:0] BANK_B_DRIVER_TYPE_OFFSET = 8'hd3;

   // Reset values; reserved bits follow the same defaults.
   localparam logic [7:0] DIRECTION_RESET = 8'h00;
   localparam logic [7:0] OUTPUT_VALUE_RESET = 8'hff;
   localparam logic [7:0] DRIVER_TYPE_RESET = 8'h00;
   localparam logic [7:0] SYNC_RESET = 8'h00;
   localparam logic [7:0] READ_IDLE = 8'h00;

   // Lines that exist in each bank; other bits are reserved.
   localparam logic [7:0] BANK_A_LINE_MASK = 8'h7f;
   localparam logic [7:0] BANK_B_LINE_MASK = 8'hf7;

   // Number of lines wired to bank A pins.
   localparam int unsigned BANK_A_LINES = 7;

   // Field values of the per-line control bits.
   localparam logic DIR_INPUT = 1'b0;
   localparam logic DIR_OUTPUT = 1'b1;
   localparam logic DRIVE_OPEN_DRAIN = 1'b0;
   localparam logic DRIVE_PUSH_PULL = 1'b1;

   // Writable state of one bank.
   typedef struct packed {
      logic [7:0] direction;
      logic [7:0] output_value;
      logic [7:0] driver_type;
   } bank_ctrl_type;

   // What one bank presents to its pads.
   typedef struct packed {
      logic [7:0] drive;
      logic [7:0] enable;
   } pad_out_type;

   // One register access from the port.
   typedef struct packed {
      logic [7:0] addr;
      logic [7:0] wdata;
      logic wr;
      logic rd;
   } reg_req_type;

   // Register selected by an address.
   typedef enum logic [3:0] {
      SEL_NONE,
      SEL_A_DIRECTION,
      SEL_A_OUTPUT_VALUE,
      SEL_A_PIN_LEVEL,
      SEL_A_DRIVER_TYPE,
      SEL_B_DIRECTION,
      SEL_B_OUTPUT_VALUE,
      SEL_B_PIN_LEVEL,
      SEL_B_DRIVER_TYPE
   } reg_sel_type;

endpackage : gpio_pkg
`default_nettype wire

// File: src/pin_sync.sv
// Two-flop synchroniser for a group of pin levels.
// Assumes the pins are asynchronous to clk; only stage two is read.
`timescale 1ns/10ps
`default_nettype none
module pin_sync
   import gpio_pkg::*;
(
   input wire logic clk,
   input wire logic reset_n,
   input wire logic [7:0] pin_async,
   output logic [7:0] pin_level
);

   logic [7:0] meta_q;
   logic [7:0] level_q;

   always_ff @(posedge clk) begin
      if (!reset_n) begin
         meta_q <= SYNC_RESET;
         level_q <= SYNC_RESET;
      end else begin
         meta_q <= pin_async;
         level_q <= meta_q;
      end
   end

   assign pin_level = level_q;

endmodule : pin_sync
`default_nettype wire

// File: src/bank_pins.sv
// Pad driver for one bank of eight lines, registered outputs.
// Assumes the board resolves the wire from drive and enable.
`timescale 1ns/10ps
`default_nettype none
module bank_pins
   import gpio_pkg::*;
#(
   parameter logic [7:0] LINE_MASK = 8'hff
) (
   input wire logic clk,
   input wire logic reset_n,
   input wire bank_ctrl_type ctrl,
   output pad_out_type pads
);

   logic [7:0] push_pull;
   logic [7:0] enable_d;
   logic [7:0] drive_d;
   pad_out_type pads_q;

   assign push_pull = ctrl.driver_type;

   // Open drain sinks only for a 0; push-pull drives both levels.
   // Input lines and reserved bits never enable a driver.
   assign enable_d = LINE_MASK & ctrl.direction
                     & (push_pull | ~ctrl.output_value);
   assign drive_d = LINE_MASK & push_pull & ctrl.output_value;

   always_ff @(posedge clk) begin
      if (!reset_n) begin
         pads_q <= '0;
      end else begin
         pads_q.enable <= enable_d;
         pads_q.drive <= drive_d;
      end
   end

   assign pads = pads_q;

endmodule : bank_pins
`default_nettype wire

// File: verif/board_lines.sv
// Board side of one bank: pull-ups and optional external drivers.
// Assumes pad enables are active high and the pad wins a contention.
`timescale 1ns/10ps
`default_nettype none
module board_lines #(
   parameter int W = 8
) (
   input wire logic [W-1:0] pad_out,
   input wire logic [W-1:0] pad_oe,
   input wire logic [W-1:0] ext_en,
   input wire logic [W-1:0] ext_val,
   output logic [W-1:0] level
);
   always_comb begin
      for (int i = 0; i < W; i++) begin
         level[i] = pad_oe[i] ? pad_out[i] : (ext_en[i] ? ext_val[i] : 1'b1);
      end
   end
endmodule : board_lines
`default_nettype wire

// File: verif/io_port_props_props.sv
// Assertions on the register port and pads of the two-bank port.
// Assumes pads follow a register write two edges later.
`timescale 1ns/10ps
`default_nettype none
module io_port_props
   import gpio_pkg::*;
(
   input wire logic clk,
   input wire logic reset_n,
   input wire logic [7:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [7:0] reg_rdata,
   input wire logic [6:0] bank_a_pin_in,
   input wire logic [6:0] bank_a_pin_out,
   input wire logic [6:0] bank_a_pin_oe,
   input wire logic [7:0] bank_b_pin_in,
   input wire logic [7:0] bank_b_pin_out,
   input wire logic [7:0] bank_b_pin_oe
);
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!reset_n);
   sequence wr_to(logic [7:0] a);
      reg_wr && reg_addr == a;
   endsequence
   sequence rd_quiet(logic [7:0] a, logic [7:0] p);
      ($stable(p) && reset_n) [*4] ##0 (reg_rd && reg_addr == a);
   endsequence
   chk_read_idle: assert property (
      reg_rdata != 8'h00 |-> $past(reg_rd)) else $error("stray read data");
   chk_a_dir_off: assert property (
      wr_to(BANK_A_DIRECTION_OFFSET) |-> ##2
      (bank_a_pin_oe & ~$past(reg_wdata[6:0], 2)) == 7'h00)
      else $error("bank a input line driven");
   chk_b_dir_off: assert property (
      wr_to(BANK_B_DIRECTION_OFFSET) |-> ##2
      (bank_b_pin_oe & ~$past(reg_wdata, 2)) == 8'h00)
      else $error("bank b input line driven");
   chk_a_value: assert property (
      wr_to(BANK_A_OUTPUT_VALUE_OFFSET) |-> ##2
      (bank_a_pin_oe & (bank_a_pin_out ^ $past(reg_wdata[6:0], 2))) == 7'h00)
      else $error("bank a drive level");
   chk_b_value: assert property (
      wr_to(BANK_B_OUTPUT_VALUE_OFFSET) |-> ##2
      (bank_b_pin_oe & (bank_b_pin_out ^ $past(reg_wdata, 2))) == 8'h00)
      else $error("bank b drive level");
   chk_a_open_drain: assert property (
      wr_to(BANK_A_DRIVER_TYPE_OFFSET) |-> ##2
      (bank_a_pin_oe & bank_a_pin_out & ~$past(reg_wdata[6:0], 2)) == 7'h00)
      else $error("bank a open drain drives high");
   chk_b_open_drain: assert property (
      wr_to(BANK_B_DRIVER_TYPE_OFFSET) |-> ##2
      (bank_b_pin_oe & bank_b_pin_out & ~$past(reg_wdata, 2)) == 8'h00)
      else $error("bank b open drain drives high");
   chk_a_level: assert property (
      rd_quiet(BANK_A_PIN_LEVEL_OFFSET, {1'b0, bank_a_pin_in}) |=>
      reg_rdata == {1'b0, $past(bank_a_pin_in)}) else $error("bank a level");
   chk_b_level: assert property (
      rd_quiet(BANK_B_PIN_LEVEL_OFFSET, bank_b_pin_in) |=>
      reg_rdata == ($past(bank_b_pin_in) & 8'hf7)) else $error("bank b level");
endmodule : io_port_props
bind dual_bank_io_port_regs io_port_props i_io_port_props (.clk, .reset_n,
   .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .bank_a_pin_in,
   .bank_a_pin_out, .bank_a_pin_oe, .bank_b_pin_in, .bank_b_pin_out,
   .bank_b_pin_oe);
`default_nettype wire

// File: verif/tb_dual_bank_io_port_regs.sv
// Self-checking bench: register tasks on the plain port and a board model.
// Assumes the board pulls released lines high.
`timescale 1ns/10ps
`default_nettype none
module tb_dual_bank_io_port_regs
   import gpio_pkg::*;
;
   logic clk = 1'b0;
   logic reset_n = 1'b0;
   logic [7:0] reg_addr = 8'h00;
   logic [7:0] reg_wdata = 8'h00;
   logic reg_wr = 1'b0;
   logic reg_rd = 1'b0;
   logic [7:0] reg_rdata;
   logic [6:0] a_in, a_out, a_oe;
   logic [7:0] b_in, b_out, b_oe;
   logic [7:0] ext_en = 8'h00;
   logic [7:0] ext_val = 8'h00;
   logic [7:0] ra [6] = '{8'he0, 8'he1, 8'he3, 8'hd0, 8'hd1, 8'hd3};
   logic [7:0] rv [6] = '{8'h00, 8'hff, 8'h00, 8'h00, 8'hff, 8'h00};
   int fail_count = 0;
   int checks_done = 0;
   dual_bank_io_port_regs i_dual_bank_io_port_regs (.clk(clk),
      .reset_n(reset_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
      .bank_a_pin_in(a_in), .bank_a_pin_out(a_out), .bank_a_pin_oe(a_oe),
      .bank_b_pin_in(b_in), .bank_b_pin_out(b_out), .bank_b_pin_oe(b_oe));
   board_lines #(.W(7)) i_board_lines_a (.pad_out(a_out), .pad_oe(a_oe),
      .ext_en(ext_en[6:0]), .ext_val(ext_val[6:0]), .level(a_in));
   board_lines #(.W(8)) i_board_lines_b (.pad_out(b_out), .pad_oe(b_oe),
      .ext_en(ext_en), .ext_val(ext_val), .level(b_in));
   initial begin
      forever #2 clk = ~clk;
   end
   task check(input string what, input logic [7:0] s, input logic [7:0] e);
      checks_done++;
      if (s !== e) begin
         fail_count++;
         $display("unexpected %s: expected %h, seen %h", what, e, s);
      end
   endtask : check
   task wr(input logic [7:0] a, input logic [7:0] v);
      @(posedge clk);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= v;
      @(posedge clk);
      reg_wr <= 1'b0;
   endtask : wr
   task rd(input logic [7:0] a, input logic [7:0] e, input string what);
      @(posedge clk);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge clk);
      reg_rd <= 1'b0;
      #1;
      check(what, reg_rdata, e);
   endtask : rd
   // Programs one bank, then checks pads and the level seen back.
   task drive(input logic [7:0] base, input logic [7:0] mask,
         input logic [7:0] dir, input logic [7:0] drv, input logic [7:0] val);
      logic [7:0] eoe;
      logic [7:0] oe;
      logic [7:0] out;
      eoe = dir & (drv | ~val) & mask;
      wr(base + 8'h03, drv);
      wr(base + 8'h01, val);
      wr(base, dir);
      repeat (6) @(posedge clk);
      #1;
      oe = (base == 8'he0) ? {1'b0, a_oe} : b_oe;
      out = (base == 8'he0) ? {1'b0, a_out} : b_out;
      check("pad enable", oe, eoe);
      check("pad drive", out & oe, eoe & drv & val);
      rd(base + 8'h02, (~eoe | (drv & val)) & mask, "level");
   endtask : drive
   task finish_test;
      $display("checks %0d, mismatches %0d", checks_done, fail_count);
      if (fail_count == 0 && checks_done > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask : finish_test
   initial begin
      #40000;
      fail_count++;
      finish_test();
   end
   initial begin
      repeat (5) @(posedge clk);
      #1;
      check("reset enable", {1'b0, a_oe} | b_oe, 8'h00);
      @(posedge clk);
      reset_n <= 1'b1;
      for (int i = 0; i < 6; i++) begin
         rd(ra[i], rv[i], "reset");
      end
      rd(8'he2, 8'h7f, "a idle level");
      rd(8'hd2, 8'hf7, "b idle level");
      wr(8'hd4, 8'hff);
      rd(8'hd4, 8'h00, "unmapped");
      for (int i = 0; i < 6; i++) begin
         wr(ra[i], 8'ha5 ^ 8'(i));
         rd(ra[i], 8'ha5 ^ 8'(i), "read back");
      end
      drive(8'he0, 8'h7f, 8'h7f, 8'h0f, 8'h55);
      drive(8'he0, 8'h7f, 8'h3c, 8'h70, 8'h2a);
      drive(8'hd0, 8'hf7, 8'hff, 8'hcc, 8'h5a);
      drive(8'hd0, 8'hf7, 8'h9b, 8'h33, 8'ha6);
      wr(8'he0, 8'h00);
      wr(8'hd0, 8'h00);
      ext_en <= 8'hff;
      ext_val <= 8'h2e;
      wr(8'he2, 8'h00);
      wr(8'hd2, 8'hff);
      repeat (4) @(posedge clk);
      rd(8'he2, 8'h2e, "a input level");
      rd(8'hd2, 8'h26, "b input level");
      rd(8'hd0, 8'h00, "b direction kept");
      @(posedge clk);
      reset_n <= 1'b0;
      repeat (2) @(posedge clk);
      reset_n <= 1'b1;
      rd(8'hd1, 8'hff, "value after reset");
      rd(8'he1, 8'hff, "a value after reset");
      rd(8'he3, 8'h00, "a driver after reset");
      finish_test();
   end
endmodule : tb_dual_bank_io_port_regs
`default_nettype wire
